// file: core/cadm_decoder.sv
// Addressing-mode decoder and effective-address sequencer.
// Assumes opcode mode and number arrive with the opcode byte, and
// memory reads answer on the same clock with a one-cycle ack.

module cadm_decoder (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Instruction byte stream
	input wire logic ib_valid,
	input wire logic [7:0] ib_data,
	output logic ib_ready,
	// Opcode side information, valid with the opcode byte
	input wire cadm_pkg::cadm_amode_t op_mode,
	input wire logic [5:0] op_id,
	input wire logic [15:0] op_pc,
	// Index registers
	input wire logic [7:0] x_val,
	input wire logic [7:0] y_val,
	// Memory read port for pointers
	output logic mem_req,
	output logic [15:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	// Decoded result
	output logic dec_valid,
	output cadm_pkg::cadm_amode_t dec_mode,
	output cadm_pkg::cadm_group_t dec_group,
	output logic [5:0] dec_id,
	output logic [2:0] dec_len,
	output logic [15:0] dec_ea,
	output logic [7:0] dec_imm,
	output logic [15:0] dec_target,
	output logic dec_use_y,
	output logic dec_illegal,
	// Power control
	input wire logic irq_wake,
	output logic wait_mode,
	output logic osc_stop
);

	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_OPND = 5'b00010,
		ST_PTR1 = 5'b00100,
		ST_PTR2 = 5'b01000,
		ST_DONE = 5'b10000
	} cadm_state_t;

	cadm_state_t state_reg;
	cadm_state_t state_next;
	cadm_pkg::cadm_amode_t mode_reg;
	logic [5:0] id_reg;
	logic [15:0] pc_reg;
	logic use_y_reg;
	logic pfx_reg;
	logic pfx_y_reg;
	logic pfx_ind_reg;
	logic pfx_iy_reg;
	logic [1:0] need_reg;
	logic [1:0] cnt_reg;
	logic [15:0] word_reg;
	logic [15:0] ptr_reg;
	logic take;
	logic is_prefix;
	logic ptr_long;
	logic [15:0] next_pc;
	cadm_pkg::cadm_amode_t mode_eff;
	logic [1:0] need_eff;
	logic done;

	cadm_ea_if ea_bus ();

	cadm_ea_calc u_calc (
		.ea(ea_bus)
	);

	// ------------------------------------------------------------
	// Classification helpers
	// ------------------------------------------------------------

	// Group from instruction number
	function automatic cadm_pkg::cadm_group_t group_of(input logic [5:0] id);
		if (id >= cadm_pkg::ID_FLAG) begin
			group_of = cadm_pkg::GR_FLAG;
		end else if (id >= cadm_pkg::ID_INT) begin
			group_of = cadm_pkg::GR_INT;
		end else if (id >= cadm_pkg::ID_COND) begin
			group_of = cadm_pkg::GR_COND;
		end else if (id >= cadm_pkg::ID_JUMP) begin
			group_of = cadm_pkg::GR_JUMP;
		end else if (id >= cadm_pkg::ID_SHIFT) begin
			group_of = cadm_pkg::GR_SHIFT;
		end else if (id >= cadm_pkg::ID_ARITH) begin
			group_of = cadm_pkg::GR_ARITH;
		end else if (id >= cadm_pkg::ID_BTJ) begin
			group_of = cadm_pkg::GR_BTJ;
		end else if (id >= cadm_pkg::ID_BIT) begin
			group_of = cadm_pkg::GR_BIT;
		end else if (id >= cadm_pkg::ID_LOGIC) begin
			group_of = cadm_pkg::GR_LOGIC;
		end else if (id >= cadm_pkg::ID_CMP) begin
			group_of = cadm_pkg::GR_CMP;
		end else if (id >= cadm_pkg::ID_INCDEC) begin
			group_of = cadm_pkg::GR_INCDEC;
		end else if (id >= cadm_pkg::ID_STACK) begin
			group_of = cadm_pkg::GR_STACK;
		end else begin
			group_of = cadm_pkg::GR_LOAD;
		end
	endfunction

	// Memory read-modify-write instructions: short forms only
	function automatic logic short_only(input logic [5:0] id);
		short_only = (id == cadm_pkg::ID_CLR) ||
			(id >= cadm_pkg::ID_INCDEC && id < cadm_pkg::ID_CMP) ||
			(id == cadm_pkg::ID_CMP + 6'h01) ||
			(id == cadm_pkg::ID_CPL) || (id == cadm_pkg::ID_NEG) ||
			(id >= cadm_pkg::ID_BIT && id < cadm_pkg::ID_ARITH) ||
			(id >= cadm_pkg::ID_SHIFT && id < cadm_pkg::ID_JUMP);
	endfunction

	// Long forms of memory access modes
	function automatic logic long_form(input cadm_pkg::cadm_amode_t m);
		long_form = (m == cadm_pkg::AM_DIR_L) || (m == cadm_pkg::AM_IDX_L) ||
			(m == cadm_pkg::AM_IND_L) || (m == cadm_pkg::AM_INDX_L);
	endfunction

	// Operand bytes after the opcode for each mode
	function automatic logic [1:0] bytes_of(input cadm_pkg::cadm_amode_t m);
		unique case (m)
			cadm_pkg::AM_INH: bytes_of = 2'h0;
			cadm_pkg::AM_IDX0: bytes_of = 2'h0;
			cadm_pkg::AM_DIR_L: bytes_of = 2'h2;
			cadm_pkg::AM_IDX_L: bytes_of = 2'h2;
			cadm_pkg::AM_IMM: bytes_of = 2'h1;
			default: bytes_of = 2'h1;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Prefix translation of the opcode's base mode
	// ------------------------------------------------------------

	// Indirect prefixes turn direct, short and long indexed and relative into indirect
	always_comb begin
		mode_eff = op_mode;
		if (pfx_ind_reg || pfx_iy_reg) begin
			unique case (op_mode)
				cadm_pkg::AM_DIR_S: mode_eff = cadm_pkg::AM_IND_S;
				cadm_pkg::AM_DIR_L: mode_eff = cadm_pkg::AM_IND_L;
				cadm_pkg::AM_IDX_S: mode_eff = cadm_pkg::AM_INDX_S;
				cadm_pkg::AM_IDX_L: mode_eff = cadm_pkg::AM_INDX_L;
				cadm_pkg::AM_REL_D: mode_eff = cadm_pkg::AM_REL_I;
				default: mode_eff = op_mode;
			endcase
		end
	end

	assign need_eff = bytes_of(mode_eff);
	assign ptr_long = (mode_reg == cadm_pkg::AM_IND_L) ||
		(mode_reg == cadm_pkg::AM_INDX_L);

	// ------------------------------------------------------------
	// Handshakes
	// ------------------------------------------------------------

	// Stream stalls in low-power states and while reading pointers
	assign ib_ready = ce && !wait_mode && !osc_stop &&
		(state_reg == ST_IDLE || state_reg == ST_OPND);
	assign take = ib_valid && ib_ready;
	assign is_prefix = (state_reg == ST_IDLE) && !pfx_reg &&
		(ib_data == cadm_pkg::y_index_prefix ||
		ib_data == cadm_pkg::y_indirect_prefix ||
		ib_data == cadm_pkg::indirect_prefix);
	assign mem_req = ce && (state_reg == ST_PTR1 || state_reg == ST_PTR2);
	assign mem_addr = ptr_reg;
	assign done = ce && (state_reg == ST_DONE);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (take && !is_prefix) begin
					state_next = (need_eff == 2'h0) ? ST_DONE : ST_OPND;
				end
			end
			ST_OPND: begin
				if (take && cnt_reg + 2'h1 == need_reg) begin
					if (mode_reg == cadm_pkg::AM_IND_S ||
						mode_reg == cadm_pkg::AM_IND_L ||
						mode_reg == cadm_pkg::AM_INDX_S ||
						mode_reg == cadm_pkg::AM_INDX_L ||
						mode_reg == cadm_pkg::AM_REL_I) begin
						state_next = ST_PTR1;
					end else begin
						state_next = ST_DONE;
					end
				end
			end
			ST_PTR1: begin
				if (mem_req && mem_ack) begin
					state_next = ptr_long ? ST_PTR2 : ST_DONE;
				end
			end
			ST_PTR2: begin
				if (mem_req && mem_ack) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Prefix capture
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pfx_reg <= 1'b0;
			pfx_y_reg <= 1'b0;
			pfx_ind_reg <= 1'b0;
			pfx_iy_reg <= 1'b0;
		end else if (ce) begin
			if (take && is_prefix) begin
				pfx_reg <= 1'b1;
				pfx_y_reg <= ib_data == cadm_pkg::y_index_prefix;
				pfx_ind_reg <= ib_data == cadm_pkg::indirect_prefix;
				pfx_iy_reg <= ib_data == cadm_pkg::y_indirect_prefix;
			end else if (done) begin
				pfx_reg <= 1'b0;
				pfx_y_reg <= 1'b0;
				pfx_ind_reg <= 1'b0;
				pfx_iy_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Opcode capture
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mode_reg <= cadm_pkg::AM_INH;
			id_reg <= 6'h00;
			pc_reg <= 16'h0000;
			use_y_reg <= 1'b0;
			need_reg <= 2'h0;
		end else if (ce && take && state_reg == ST_IDLE && !is_prefix) begin
			mode_reg <= mode_eff;
			id_reg <= op_id;
			pc_reg <= op_pc;
			use_y_reg <= pfx_y_reg || pfx_iy_reg;
			need_reg <= need_eff;
		end
	end

	// ------------------------------------------------------------
	// Operand bytes, high byte first
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_reg <= 2'h0;
			word_reg <= 16'h0000;
		end else if (ce) begin
			if (take && state_reg == ST_IDLE) begin
				cnt_reg <= 2'h0;
				word_reg <= 16'h0000;
			end else if (take && state_reg == ST_OPND) begin
				cnt_reg <= cnt_reg + 2'h1;
				word_reg <= {word_reg[7:0], ib_data};
			end
		end
	end

	// ------------------------------------------------------------
	// Pointer reads from the zero page
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ptr_reg <= 16'h0000;
		end else if (ce) begin
			if (take && state_reg == ST_OPND) begin
				ptr_reg <= {cadm_pkg::ZERO_PAGE, ib_data};
			end else if (mem_req && mem_ack && state_reg == ST_PTR1) begin
				ptr_reg <= {cadm_pkg::ZERO_PAGE, ptr_reg[7:0] + 8'h01};
			end
		end
	end

	// Pointer value replaces the operand word
	logic [15:0] ptr_val_reg;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ptr_val_reg <= 16'h0000;
		end else if (ce && mem_req && mem_ack) begin
			if (state_reg == ST_PTR1) begin
				ptr_val_reg <= {8'h00, mem_rdata};
			end else begin
				ptr_val_reg <= {ptr_val_reg[7:0], mem_rdata};
			end
		end
	end

	// ------------------------------------------------------------
	// Address adder inputs
	// ------------------------------------------------------------

	// Address after the whole instruction, prefix excluded from PC base
	assign next_pc = pc_reg + {14'h0000, need_reg} + 16'h0001;

	always_comb begin
		ea_bus.base = word_reg;
		ea_bus.idx = use_y_reg ? y_val : x_val;
		ea_bus.use_idx = 1'b0;
		ea_bus.disp = 8'h00;
		ea_bus.rel = 1'b0;
		unique case (mode_reg)
			cadm_pkg::AM_IDX0: begin
				ea_bus.base = 16'h0000;
				ea_bus.use_idx = 1'b1;
			end
			cadm_pkg::AM_IDX_S, cadm_pkg::AM_IDX_L: begin
				ea_bus.use_idx = 1'b1;
			end
			cadm_pkg::AM_IND_S, cadm_pkg::AM_IND_L: begin
				ea_bus.base = ptr_val_reg;
			end
			cadm_pkg::AM_INDX_S, cadm_pkg::AM_INDX_L: begin
				ea_bus.base = ptr_val_reg;
				ea_bus.use_idx = 1'b1;
			end
			cadm_pkg::AM_REL_D: begin
				ea_bus.base = next_pc;
				ea_bus.disp = word_reg[7:0];
				ea_bus.rel = 1'b1;
			end
			cadm_pkg::AM_REL_I: begin
				ea_bus.base = next_pc;
				ea_bus.disp = ptr_val_reg[7:0];
				ea_bus.rel = 1'b1;
			end
			default: ea_bus.base = word_reg;
		endcase
	end

	// ------------------------------------------------------------
	// Decoded result registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dec_valid <= 1'b0;
			dec_mode <= cadm_pkg::AM_INH;
			dec_group <= cadm_pkg::GR_LOAD;
			dec_id <= 6'h00;
			dec_len <= 3'h0;
			dec_ea <= 16'h0000;
			dec_imm <= 8'h00;
			dec_target <= 16'h0000;
			dec_use_y <= 1'b0;
			dec_illegal <= 1'b0;
		end else if (ce) begin
			dec_valid <= done;
			if (done) begin
				dec_mode <= mode_reg;
				dec_group <= group_of(id_reg);
				dec_id <= id_reg;
				dec_len <= {1'b0, need_reg} + 3'h1 + {2'h0, pfx_reg};
				dec_ea <= ea_bus.rel ? 16'h0000 : ea_bus.sum;
				dec_imm <= (mode_reg == cadm_pkg::AM_IMM) ?
					word_reg[7:0] : 8'h00;
				dec_target <= ea_bus.rel ? ea_bus.sum : next_pc;
				dec_use_y <= use_y_reg;
				// Beyond the instruction count, or a long form on a
				// short-only instruction; long-and-short ones pass
				dec_illegal <= (id_reg >= cadm_pkg::ID_COUNT) ||
					(short_only(id_reg) && long_form(mode_reg));
			end
		end
	end

	// ------------------------------------------------------------
	// Low-power requests
	// ------------------------------------------------------------

	// Wait: stream stalls until an interrupt arrives
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wait_mode <= 1'b0;
		end else if (ce) begin
			if (irq_wake) begin
				wait_mode <= 1'b0;
			end else if (done && id_reg == cadm_pkg::wait_for_irq_op) begin
				wait_mode <= 1'b1;
			end
		end
	end

	// Halt: oscillator stop held until an interrupt wakes the core
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			osc_stop <= 1'b0;
		end else if (ce) begin
			if (irq_wake) begin
				osc_stop <= 1'b0;
			end else if (done && id_reg == cadm_pkg::ID_HALT) begin
				osc_stop <= 1'b1;
			end
		end
	end

endmodule // cadm_decoder

// file: shared/cadm_pkg.sv
// Constants and types for the addressing-mode decoder.
// Assumes a byte-wide instruction stream and a 64 Kbyte byte-addressed space.
package cadm_pkg;

	// ------------------------------------------------------------
	// Prefix bytes
	// ------------------------------------------------------------
	localparam logic [7:0] y_index_prefix = 8'h90;
	localparam logic [7:0] y_indirect_prefix = 8'h91;
	localparam logic [7:0] indirect_prefix = 8'h92;

	// ------------------------------------------------------------
	// Effective addressing modes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		AM_INH = 4'h0,
		AM_IMM = 4'h1,
		AM_DIR_S = 4'h2,
		AM_DIR_L = 4'h3,
		AM_IDX0 = 4'h4,
		AM_IDX_S = 4'h5,
		AM_IDX_L = 4'h6,
		AM_IND_S = 4'h7,
		AM_IND_L = 4'h8,
		AM_INDX_S = 4'h9,
		AM_INDX_L = 4'hA,
		AM_REL_D = 4'hB,
		AM_REL_I = 4'hC
	} cadm_amode_t;

	// ------------------------------------------------------------
	// Functional groups
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		GR_LOAD = 4'h0,
		GR_STACK = 4'h1,
		GR_INCDEC = 4'h2,
		GR_CMP = 4'h3,
		GR_LOGIC = 4'h4,
		GR_BIT = 4'h5,
		GR_BTJ = 4'h6,
		GR_ARITH = 4'h7,
		GR_SHIFT = 4'h8,
		GR_JUMP = 4'h9,
		GR_COND = 4'hA,
		GR_INT = 4'hB,
		GR_FLAG = 4'hC
	} cadm_group_t;

	// ------------------------------------------------------------
	// Instruction numbering: first number of each group, then the instruction count
	// ------------------------------------------------------------
	localparam logic [5:0] ID_STACK = 6'h02;
	localparam logic [5:0] ID_INCDEC = 6'h05;
	localparam logic [5:0] ID_CMP = 6'h07;
	localparam logic [5:0] ID_LOGIC = 6'h0A;
	localparam logic [5:0] ID_BIT = 6'h0F;
	localparam logic [5:0] ID_BTJ = 6'h11;
	localparam logic [5:0] ID_ARITH = 6'h13;
	localparam logic [5:0] ID_SHIFT = 6'h18;
	localparam logic [5:0] ID_JUMP = 6'h1F;
	localparam logic [5:0] ID_COND = 6'h27;
	localparam logic [5:0] ID_INT = 6'h37;
	localparam logic [5:0] ID_FLAG = 6'h3B;
	localparam logic [5:0] ID_COUNT = 6'h3F;

	// Individual instruction numbers; CLR, CPL, NEG, wait and HALT are treated specially by the decoder
	localparam logic [5:0] ID_LD = 6'h00;
	localparam logic [5:0] ID_CLR = 6'h01;
	localparam logic [5:0] ID_CPL = 6'h0D;
	localparam logic [5:0] ID_NEG = 6'h0E;
	localparam logic [5:0] ID_MUL = 6'h17;
	localparam logic [5:0] ID_JP = 6'h22;
	localparam logic [5:0] ID_CALL = 6'h23;
	localparam logic [5:0] wait_for_irq_op = 6'h38;
	localparam logic [5:0] ID_HALT = 6'h39;

	// Zero page high byte
	localparam logic [7:0] ZERO_PAGE = 8'h00;

endpackage : cadm_pkg

// file: shared/cadm_ea_if.sv
// Carrier between the decoder sequencer and its address adder.
// Assumes both ends sit on the same clock; the adder is combinational.
interface cadm_ea_if;
	logic [15:0] base;
	logic [7:0] idx;
	logic use_idx;
	logic [7:0] disp;
	logic rel;
	logic [15:0] sum;

	modport calc (
		input base,
		input idx,
		input use_idx,
		input disp,
		input rel,
		output sum
	);

	modport user (
		output base,
		output idx,
		output use_idx,
		output disp,
		output rel,
		input sum
	);
endinterface : cadm_ea_if

// file: core/cadm_ea_calc.sv
// Effective-address adder: unsigned index sum or signed PC offset.
// Assumes the caller holds its inputs stable for the cycle it samples sum.
module cadm_ea_calc (
	// Address terms and result
	cadm_ea_if.calc ea
);

	logic [15:0] idx_ext;
	logic [15:0] disp_ext;

	// Unsigned index extension, sign extension of the offset
	assign idx_ext = ea.use_idx ? {8'h00, ea.idx} : 16'h0000;
	assign disp_ext = {{8{ea.disp[7]}}, ea.disp};

	// Wraps within the 64 Kbyte space
	assign ea.sum = ea.rel ? ea.base + disp_ext : ea.base + idx_ext;

endmodule // cadm_ea_calc

// file: dv/cadm_decoder_monitor.sv
// Checker for the addressing-mode decoder, bound to its top ports.
// Assumes the decoder is the top module and runs on one clock.
module cadm_decoder_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Handshakes
	input wire logic ib_ready,
	input wire logic mem_req,
	input wire logic [15:0] mem_addr,
	input wire logic mem_ack,
	// Decoded result
	input wire logic dec_valid,
	input wire cadm_pkg::cadm_amode_t dec_mode,
	input wire logic [5:0] dec_id,
	input wire logic [2:0] dec_len,
	input wire logic [15:0] dec_ea,
	input wire logic dec_use_y,
	input wire logic dec_illegal,
	// Power control
	input wire logic irq_wake,
	input wire logic wait_mode,
	input wire logic osc_stop
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// Lengths, address ranges and illegal forms of results
	// ------------------------------------------------------------
	inh_len_a: assert property (
		dec_valid && dec_mode == cadm_pkg::AM_INH
		|-> dec_len == (dec_use_y ? 3'h2 : 3'h1)) else $error("inherent len");
	dirl_len_a: assert property (
		dec_valid && dec_mode == cadm_pkg::AM_DIR_L
		|-> dec_len == 3'h3) else $error("long direct len");
	dirs_page_a: assert property (
		dec_valid && dec_mode == cadm_pkg::AM_DIR_S
		|-> dec_ea[15:8] == 8'h00) else $error("short direct page");
	idx0_page_a: assert property (
		dec_valid && dec_mode == cadm_pkg::AM_IDX0
		|-> dec_ea[15:8] == 8'h00) else $error("no offset page");
	short_sum_a: assert property (
		dec_valid && (dec_mode == cadm_pkg::AM_IDX_S
		|| dec_mode == cadm_pkg::AM_INDX_S) |-> dec_ea <= 16'h01FE)
		else $error("short indexed range");
	ind_len_a: assert property (
		dec_valid && dec_mode >= cadm_pkg::AM_IND_S
		&& dec_mode != cadm_pkg::AM_REL_D |-> dec_len == 3'h3)
		else $error("indirect len");
	rmw_long_a: assert property (
		dec_valid && dec_id == cadm_pkg::ID_CLR
		&& dec_mode == cadm_pkg::AM_DIR_L |-> dec_illegal)
		else $error("long clr");

	// ------------------------------------------------------------
	// Handshakes and power states
	// ------------------------------------------------------------
	ptr_page_a: assert property (mem_req |-> mem_addr[15:8] == 8'h00)
		else $error("pointer outside zero page");
	ptr_hold_a: assert property (mem_req && !mem_ack && ce
		|=> mem_req && $stable(mem_addr)) else $error("pointer read dropped");
	pulse_one_a: assert property (dec_valid && ce |=> !dec_valid)
		else $error("result pulse too long");
	sleep_block_a: assert property (
		wait_mode || osc_stop |-> !ib_ready)
		else $error("stream taken while asleep");
	wake_clear_a: assert property (irq_wake && ce
		|=> !wait_mode && !osc_stop) else $error("wake ignored");

	// Main scenarios reached
	rel_i_c: cover property (dec_valid && dec_mode == cadm_pkg::AM_REL_I);
	ptr_rd_c: cover property (mem_req && mem_ack);
	wait_c: cover property (wait_mode);
	halt_c: cover property (osc_stop);
endmodule // cadm_decoder_monitor

bind cadm_decoder cadm_decoder_monitor u_cadm_decoder_monitor (
	.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .ib_ready(ib_ready),
	.mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
	.dec_valid(dec_valid), .dec_mode(dec_mode), .dec_id(dec_id),
	.dec_len(dec_len), .dec_ea(dec_ea), .dec_use_y(dec_use_y),
	.dec_illegal(dec_illegal), .irq_wake(irq_wake),
	.wait_mode(wait_mode), .osc_stop(osc_stop));

// file: dv/tb.sv
// Self-checking bench for the addressing-mode decoder.
// Assumes pointer memory answers at the falling edge, optionally slowly.
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, ib_valid = 1'b0;
	logic [7:0] ib_data = 8'h00, x_val = 8'h00, y_val = 8'h00;
	cadm_pkg::cadm_amode_t op_mode = cadm_pkg::AM_INH;
	logic [5:0] op_id = 6'h00;
	logic [15:0] op_pc = 16'h1000;
	logic mem_ack = 1'b0, slow = 1'b0, tgl = 1'b0, irq_wake = 1'b0;
	logic [7:0] mem_rdata = 8'h00;
	logic ib_ready, mem_req, dec_valid, dec_use_y, dec_illegal;
	logic wait_mode, osc_stop;
	logic [15:0] mem_addr, dec_ea, dec_target;
	logic [7:0] dec_imm;
	logic [5:0] dec_id;
	logic [2:0] dec_len;
	cadm_pkg::cadm_amode_t dec_mode;
	cadm_pkg::cadm_group_t dec_group;
	int errors = 0, comparisons = 0;

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	cadm_decoder u_cadm_decoder (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
		.ib_valid(ib_valid), .ib_data(ib_data), .ib_ready(ib_ready),
		.op_mode(op_mode), .op_id(op_id), .op_pc(op_pc), .x_val(x_val),
		.y_val(y_val), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .dec_valid(dec_valid),
		.dec_mode(dec_mode), .dec_group(dec_group), .dec_id(dec_id),
		.dec_len(dec_len), .dec_ea(dec_ea), .dec_imm(dec_imm),
		.dec_target(dec_target), .dec_use_y(dec_use_y),
		.dec_illegal(dec_illegal), .irq_wake(irq_wake),
		.wait_mode(wait_mode), .osc_stop(osc_stop));

	// Pointer memory content
	function automatic logic [7:0] mb(input logic [7:0] a);
		return a ^ 8'h3C;
	endfunction

	// Pointer memory; idle data keeps changing so stale reads show
	always @(negedge sys_clk) begin
		tgl <= ~tgl;
		mem_ack <= mem_req && (!slow || tgl);
		mem_rdata <= (mem_req && (!slow || tgl)) ? mb(mem_addr[7:0]) : ~mem_rdata;
	end

	task print_verdict;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask

	// One stream byte, held until taken
	task sb(input logic [7:0] b);
		int k;
		ib_valid = 1'b1;
		ib_data = b;
		for (k = 0; k < 50 && ib_ready !== 1'b1; k++) @(negedge sys_clk);
		if (k == 50) begin
			errors++;
			print_verdict;
		end
		@(negedge sys_clk);
	endtask

	// Whole instruction, then wait for the result pulse
	task ins(input logic [7:0] pre, input cadm_pkg::cadm_amode_t m,
		input logic [5:0] id, input logic [7:0] b0, input logic [7:0] b1,
		input int n);
		int k;
		op_mode = m;
		op_id = id;
		if (pre != 8'h00) sb(pre);
		sb(8'hA6);
		if (n > 0) sb(b0);
		if (n > 1) sb(b1);
		ib_valid = 1'b0;
		for (k = 0; k < 50 && dec_valid !== 1'b1; k++) @(negedge sys_clk);
		if (k == 50) begin
			errors++;
			print_verdict;
		end
	endtask

	// Plain modes: inherent, immediate, direct and indexed
	task t_plain;
		ins(8'h00, cadm_pkg::AM_INH, cadm_pkg::ID_LD, 8'h00, 8'h00, 0);
		chk("inh len", 16'h0001, {13'h0, dec_len});
		ins(8'h00, cadm_pkg::AM_IMM, cadm_pkg::ID_CMP, 8'hA5, 8'h00, 1);
		chk("imm val", 16'h00A5, {8'h0, dec_imm});
		chk("imm len", 16'h0002, {13'h0, dec_len});
		ins(8'h00, cadm_pkg::AM_DIR_S, cadm_pkg::ID_LD, 8'hFF, 8'h00, 1);
		chk("dir s ea", 16'h00FF, dec_ea);
		ins(8'h00, cadm_pkg::AM_DIR_L, cadm_pkg::ID_LD, 8'h12, 8'h34, 2);
		chk("dir l ea", 16'h1234, dec_ea);
		chk("dir l next", 16'h1003, dec_target);
		x_val = 8'hFF;
		y_val = 8'h34;
		ins(8'h00, cadm_pkg::AM_IDX0, cadm_pkg::ID_LD, 8'h00, 8'h00, 0);
		chk("idx0 ea", 16'h00FF, dec_ea);
		ins(8'h00, cadm_pkg::AM_IDX_S, cadm_pkg::ID_LD, 8'hFF, 8'h00, 1);
		chk("idx s ea", 16'h01FE, dec_ea);
		ins(8'h90, cadm_pkg::AM_IDX_L, cadm_pkg::ID_CMP, 8'h12, 8'h00, 2);
		chk("idx l ea", 16'h1234, dec_ea);
		chk("idx l y", 16'h0001, {15'h0, dec_use_y});
		chk("idx l len", 16'h0004, {13'h0, dec_len});
	endtask

	// Pointer modes, slow memory on all but the first
	task t_ptr;
		ins(8'h92, cadm_pkg::AM_DIR_S, cadm_pkg::ID_LD, 8'h40, 8'h00, 1);
		chk("ind s mode", 16'h0007, {12'h0, dec_mode});
		chk("ind s ea", 16'h007C, dec_ea);
		slow = 1'b1;
		ins(8'h92, cadm_pkg::AM_DIR_L, cadm_pkg::ID_LD, 8'hFF, 8'h00, 1);
		chk("ind l ea", 16'hC33C, dec_ea);
		ins(8'h92, cadm_pkg::AM_IDX_S, cadm_pkg::ID_LD, 8'h10, 8'h00, 1);
		chk("indx s ea", 16'h012B, dec_ea);
		y_val = 8'h80;
		ins(8'h91, cadm_pkg::AM_IDX_L, cadm_pkg::ID_LD, 8'h20, 8'h00, 1);
		chk("indx l ea", 16'h1C9D, dec_ea);
		chk("indx l y", 16'h0001, {15'h0, dec_use_y});
		slow = 1'b0;
	endtask

	// Relative jumps at both ends of the signed range
	task t_rel;
		ins(8'h00, cadm_pkg::AM_REL_D, cadm_pkg::ID_COND, 8'h80, 8'h00, 1);
		chk("rel neg", 16'h0F82, dec_target);
		chk("rel ea", 16'h0000, dec_ea);
		ins(8'h00, cadm_pkg::AM_REL_D, cadm_pkg::ID_COND, 8'h7F, 8'h00, 1);
		chk("rel pos", 16'h1081, dec_target);
		ins(8'h92, cadm_pkg::AM_REL_D, cadm_pkg::ID_COND, 8'h30, 8'h00, 1);
		chk("rel ind", 16'h100E, dec_target);
	endtask

	// Groups, illegal forms, and the two sleep instructions
	task t_class;
		logic [5:0] gs [13];
		gs = '{6'h00, cadm_pkg::ID_STACK, cadm_pkg::ID_INCDEC, cadm_pkg::ID_CMP,
			cadm_pkg::ID_LOGIC, cadm_pkg::ID_BIT, cadm_pkg::ID_BTJ,
			cadm_pkg::ID_ARITH, cadm_pkg::ID_SHIFT, cadm_pkg::ID_JUMP,
			cadm_pkg::ID_COND, cadm_pkg::ID_INT, cadm_pkg::ID_FLAG};
		for (int i = 0; i < 13; i++) begin
			ins(8'h00, cadm_pkg::AM_INH, gs[i], 8'h00, 8'h00, 0);
			chk("group", 16'(i), {12'h0, dec_group});
			chk("group id", {10'h0, gs[i]}, {10'h0, dec_id});
		end
		ins(8'h00, cadm_pkg::AM_INH, cadm_pkg::ID_COUNT, 8'h00, 8'h00, 0);
		chk("id 63", 16'h0001, {15'h0, dec_illegal});
		ins(8'h00, cadm_pkg::AM_DIR_L, cadm_pkg::ID_CLR, 8'h12, 8'h34, 2);
		chk("clr long", 16'h0001, {15'h0, dec_illegal});
		ins(8'h00, cadm_pkg::AM_DIR_L, cadm_pkg::ID_ARITH, 8'h12, 8'h34, 2);
		chk("add long", 16'h0000, {15'h0, dec_illegal});
		ins(8'h00, cadm_pkg::AM_INH, cadm_pkg::wait_for_irq_op, 8'h0, 8'h0, 0);
		repeat (3) @(negedge sys_clk);
		chk("wait", 16'h0001, {15'h0, wait_mode});
		chk("wait ready", 16'h0000, {15'h0, ib_ready});
		irq_wake = 1'b1;
		@(negedge sys_clk);
		irq_wake = 1'b0;
		chk("woken", 16'h0000, {15'h0, wait_mode});
		chk("woken ready", 16'h0001, {15'h0, ib_ready});
		ins(8'h00, cadm_pkg::AM_INH, cadm_pkg::ID_HALT, 8'h00, 8'h00, 0);
		repeat (3) @(negedge sys_clk);
		chk("halt", 16'h0001, {15'h0, osc_stop});
		chk("halt ready", 16'h0000, {15'h0, ib_ready});
		irq_wake = 1'b1;
		@(negedge sys_clk);
		irq_wake = 1'b0;
		chk("halt woken", 16'h0000, {15'h0, osc_stop});
	endtask

	// Main sequence
	initial begin
		repeat (16) @(negedge sys_clk);
		rst_n = 1'b1;
		ce = 1'b0;
		@(negedge sys_clk);
		chk("ce ready", 16'h0000, {15'h0, ib_ready});
		ce = 1'b1;
		t_plain;
		t_ptr;
		t_rel;
		t_class;
		print_verdict;
	end
endmodule // tb
